// ---- dphp_pkg.sv ----
// Package: constants and types for the dual parallel handshake port
package dphp_pkg;
    localparam int DATA_W = 16;
    localparam logic [15:0] HOST_BASE = 16'hF340;
    localparam logic [15:0] WIN_STEP = 16'h0008;
    localparam logic [7:0] OFF_DATA0 = 8'h00;
    localparam logic [7:0] OFF_DATA1 = 8'h04;
    localparam logic [7:0] OFF_CFG0 = 8'h08;
    localparam logic [7:0] OFF_CFG1 = 8'h0C;
    localparam logic [7:0] OFF_MASK0 = 8'h10;
    localparam logic [7:0] OFF_MASK1 = 8'h14;
    localparam logic [7:0] OFF_STAT0 = 8'h18;
    localparam logic [7:0] OFF_STAT1 = 8'h1C;
    localparam logic [7:0] OFF_ID = 8'h20;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_INVF_BIT = 2;
    localparam int CFG_INVC_BIT = 3;
    localparam int CFG_TMO_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_TMO_BIT = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_FF00;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam int TICK_NS = 1000;
    localparam int CLK_NS = 4;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        DPHP_MODE_NONE = 2'd0,
        DPHP_MODE_IN = 2'd1,
        DPHP_MODE_HSOUT = 2'd2,
        DPHP_MODE_STBOUT = 2'd3
    } dphp_mode_e;

    typedef struct packed {
        logic [DATA_W-1:0] data_out;
        logic [DATA_W-1:0] data_oe;
        logic port_direction_out;
        logic port_control_out;
    } dphp_pin_out_s;

    typedef struct packed {
        logic [DATA_W-1:0] data_in;
        logic port_output_enable_in;
        logic peripheral_flag_in;
    } dphp_pin_in_s;

    typedef struct packed {
        dphp_mode_e mode;
        logic inv_flag;
        logic inv_ctrl;
        logic [7:0] timeout;
        logic [DATA_W-1:0] dir_mask;
        logic [DATA_W-1:0] wdata;
    } dphp_cfg_s;
endpackage

// ---- dphp_port.sv ----
// One handshake port: pin sync, mode sequencing and timeout
`timescale 1ns/1ns
module dphp_port
    import dphp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input dphp_pkg::dphp_cfg_s cfg,
    input wire logic start,
    input dphp_pkg::dphp_pin_in_s pin_in,
    output dphp_pkg::dphp_pin_out_s pin_out,
    output logic busy,
    output logic done_pulse,
    output logic tmo_pulse,
    output logic [dphp_pkg::DATA_W-1:0] rdata
);
    import dphp_pkg::*;

    typedef enum logic [1:0] {
        DPHP_IDLE, DPHP_WAIT_ACK, DPHP_WAIT_REL
    } dphp_st_e;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] flag_sy_reg, oe_sy_reg;
    logic flag_reg, oe_reg;
    logic [DATA_W-1:0] d1_reg, d2_reg, d3_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_sy_reg <= 3'h0;
            oe_sy_reg <= 3'h7;
            flag_reg <= 1'b0;
            oe_reg <= 1'b1;
            d1_reg <= '0;
            d2_reg <= '0;
            d3_reg <= '0;
        end else begin
            flag_sy_reg <= {flag_sy_reg[1:0], pin_in.peripheral_flag_in};
            oe_sy_reg <= {oe_sy_reg[1:0], pin_in.port_output_enable_in};
            if (flag_sy_reg[1] == flag_sy_reg[2]) flag_reg <= flag_sy_reg[2];
            if (oe_sy_reg[1] == oe_sy_reg[2]) oe_reg <= oe_sy_reg[2];
            d1_reg <= pin_in.data_in;
            d2_reg <= d1_reg;
            d3_reg <= d2_reg;
        end
    end

    // Flag level after optional inversion
    logic flag_act;
    assign flag_act = flag_reg ^ cfg.inv_flag;

    // ------------------------------------------------------------
    // Handshake sequencer
    // ------------------------------------------------------------
    dphp_st_e st_reg, st_next;
    logic ctrl_reg, ctrl_next;
    logic dir_next;
    logic [7:0] tick_reg, tick_next;
    logic [15:0] pre_reg, pre_next;
    logic done_next, tmo_next;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        st_next = st_reg;
        ctrl_next = ctrl_reg;
        tick_next = tick_reg;
        pre_next = pre_reg;
        done_next = 1'b0;
        tmo_next = 1'b0;
        rdata_next = rdata;
        // Port drives out when any mask bit is an output, except in input mode
        dir_next = (cfg.mode != DPHP_MODE_IN) && (|cfg.dir_mask);
        if (st_reg != DPHP_IDLE) begin
            if (pre_reg == 16'(TICK_CYC - 1)) begin
                pre_next = 16'h0;
                tick_next = tick_reg + 8'h1;
            end else begin
                pre_next = pre_reg + 16'h1;
            end
        end
        case (st_reg)
            DPHP_IDLE: begin
                tick_next = 8'h0;
                pre_next = 16'h0;
                if (start) begin
                    if (cfg.mode == DPHP_MODE_NONE) begin
                        rdata_next = d3_reg;
                        done_next = 1'b1;
                    end else begin
                        ctrl_next = 1'b1;
                        st_next = DPHP_WAIT_ACK;
                    end
                end
            end
            DPHP_WAIT_ACK: begin
                if (flag_act) begin
                    if (cfg.mode == DPHP_MODE_IN) rdata_next = d3_reg;
                    ctrl_next = 1'b0;
                    st_next = DPHP_WAIT_REL;
                end else if (cfg.mode == DPHP_MODE_STBOUT &&
                             pre_reg == 16'h3) begin
                    // Strobe output needs no acknowledge
                    ctrl_next = 1'b0;
                    done_next = 1'b1;
                    st_next = DPHP_IDLE;
                end
            end
            DPHP_WAIT_REL: begin
                if (!flag_act) begin
                    done_next = 1'b1;
                    st_next = DPHP_IDLE;
                end
            end
            default: st_next = DPHP_IDLE;
        endcase
        if (st_reg != DPHP_IDLE && tick_reg >= cfg.timeout &&
            cfg.timeout != 8'h0) begin
            ctrl_next = 1'b0;
            tmo_next = 1'b1;
            done_next = 1'b0;
            st_next = DPHP_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= DPHP_IDLE;
            ctrl_reg <= 1'b0;
            tick_reg <= 8'h0;
            pre_reg <= 16'h0;
            done_pulse <= 1'b0;
            tmo_pulse <= 1'b0;
            rdata <= '0;
            pin_out <= '0;
        end else begin
            st_reg <= st_next;
            ctrl_reg <= ctrl_next;
            tick_reg <= tick_next;
            pre_reg <= pre_next;
            done_pulse <= done_next;
            tmo_pulse <= tmo_next;
            rdata <= rdata_next;
            pin_out.data_out <= cfg.wdata;
            // Per-bit direction, dropped while peripheral disables
            pin_out.data_oe <= oe_reg ? cfg.dir_mask : '0;
            pin_out.port_direction_out <= dir_next;
            pin_out.port_control_out <= ctrl_next ^ cfg.inv_ctrl;
        end
    end
    assign busy = (st_reg != DPHP_IDLE);

    a_oe_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !oe_reg |=> pin_out.data_oe == '0) else $error("oe not gated");
    a_ctrl_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg == DPHP_WAIT_ACK && flag_act && !tmo_next |=> !ctrl_reg)
        else $error("ctrl held after ack");
    a_tmo_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        tmo_pulse |-> st_reg == DPHP_IDLE && !ctrl_reg)
        else $error("timeout left busy");
    a_ctrl_start: assert property (@(posedge aclk) disable iff (!aresetn)
        st_reg == DPHP_IDLE && start && cfg.mode != DPHP_MODE_NONE
        |=> ctrl_reg ##1 pin_out.port_control_out == !cfg.inv_ctrl)
        else $error("ctrl not raised");
    c_full_hs: cover property (@(posedge aclk) disable iff (!aresetn)
        st_reg == DPHP_WAIT_REL ##[1:50] done_pulse);
    c_timeout: cover property (@(posedge aclk) disable iff (!aresetn)
        tmo_pulse);
endmodule // dphp_port

// ---- dphp_top.sv ----
// Top: AXI4-Lite slave, board window decode, two handshake ports
//
// Operation
// - Three switches pick one of eight windows
// - Even and odd port numbers per board
// - Direction output shows data flow way
// - Peripheral output-enable stops data drive
// - Control asserted when output data valid
// - Control asserted while capturing input
// - Each data line input or output
// - Flag and control polarity invertible
// - Data lines carry both directions
// - Four modes: none, input, handshake, strobe
// - Handshake timeout abandons the transfer
// - Direction mask sets each line's way
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module dphp_top
    import dphp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic board_select_bit0,
    input wire logic board_select_bit1,
    input wire logic board_select_bit2,
    input wire logic unused_switch,
    input wire logic [15:0] host_addr,
    input wire logic [31:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [31:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic board_hit,
    output logic [3:0] even_port_num,
    output logic [3:0] odd_port_num,
    input dphp_pkg::dphp_pin_in_s even_port_in,
    output dphp_pkg::dphp_pin_out_s even_port_out,
    input dphp_pkg::dphp_pin_in_s odd_port_in,
    output dphp_pkg::dphp_pin_out_s odd_port_out
);
    import dphp_pkg::*;

    // ------------------------------------------------------------
    // Board position (switches are static straps)
    // ------------------------------------------------------------
    logic [2:0] pos_reg;
    logic [15:0] win_base;
    always_ff @(posedge aclk) begin
        // Fourth switch deliberately not sampled
        pos_reg <= {board_select_bit2, board_select_bit1,
                    board_select_bit0};
        if (!aresetn) begin
            board_hit <= 1'b0;
            even_port_num <= 4'h0;
            odd_port_num <= 4'h1;
        end else begin
            board_hit <= (host_addr[15:3] == win_base[15:3]);
            even_port_num <= {pos_reg, 1'b0};
            odd_port_num <= {pos_reg, 1'b1};
        end
    end
    // ON switch reads low, so all ON is position 0, the lowest window
    assign win_base = HOST_BASE + {10'h0, pos_reg, 3'h0};

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] cfg_reg [2];
    logic [15:0] mask_reg [2];
    logic [15:0] wdat_reg [2];
    logic [1:0] done_reg, tmo_reg;
    logic [1:0] start_reg;
    logic [1:0] busy_w, done_w, tmo_w;
    logic [15:0] rd_w [2];
    dphp_cfg_s cfg_w [2];

    function automatic logic [31:0] wmerge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            if (strb[i]) old[i*8 +: 8] = nw[i*8 +: 8];
        return old;
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic aw_have, w_have;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic wr_go;
    assign wr_go = aw_have && w_have && !s_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_a <= 8'h0;
            w_d <= 32'h0;
            w_s <= 4'h0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            start_reg <= 2'b00;
            done_reg <= 2'b00;
            tmo_reg <= 2'b00;
            for (int p = 0; p < 2; p++) begin
                cfg_reg[p] <= CFG_RESET;
                mask_reg[p] <= MASK_RESET;
                wdat_reg[p] <= 16'h0;
            end
        end else begin
            s_awready <= !aw_have && !s_awready;
            s_wready <= !w_have && !s_wready;
            if (s_awvalid && s_awready) begin
                aw_have <= 1'b1;
                aw_a <= s_awaddr[7:0];
            end
            if (s_wvalid && s_wready) begin
                w_have <= 1'b1;
                w_d <= s_wdata;
                w_s <= s_wstrb;
            end
            if (s_bvalid && s_bready) s_bvalid <= 1'b0;
            start_reg <= 2'b00;
            // Hardware set beats software clear
            done_reg <= done_reg | done_w;
            tmo_reg <= tmo_reg | tmo_w;
            if (wr_go) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= RESP_OKAY;
                case (aw_a)
                    OFF_DATA0, OFF_DATA1: begin
                        wdat_reg[aw_a[2]] <= 16'(wmerge({16'h0,
                            wdat_reg[aw_a[2]]}, w_d, w_s));
                        start_reg[aw_a[2]] <= 1'b1;
                    end
                    OFF_CFG0, OFF_CFG1:
                        cfg_reg[aw_a[2]] <= wmerge(cfg_reg[aw_a[2]], w_d, w_s);
                    OFF_MASK0, OFF_MASK1:
                        mask_reg[aw_a[2]] <= 16'(wmerge({16'h0,
                            mask_reg[aw_a[2]]}, w_d, w_s));
                    OFF_STAT0, OFF_STAT1: begin
                        done_reg[aw_a[2]] <= done_w[aw_a[2]] |
                            (done_reg[aw_a[2]] & ~w_d[STAT_DONE_BIT]);
                        tmo_reg[aw_a[2]] <= tmo_w[aw_a[2]] |
                            (tmo_reg[aw_a[2]] & ~w_d[STAT_TMO_BIT]);
                    end
                    default: s_bresp <= RESP_SLVERR;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic rd_err;
    always_comb begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        case (s_araddr[7:0])
            OFF_DATA0, OFF_DATA1: rd_mux = {16'h0, rd_w[s_araddr[2]]};
            OFF_CFG0, OFF_CFG1: rd_mux = cfg_reg[s_araddr[2]];
            OFF_MASK0, OFF_MASK1: rd_mux = {16'h0, mask_reg[s_araddr[2]]};
            OFF_STAT0, OFF_STAT1: rd_mux = {29'h0, tmo_reg[s_araddr[2]],
                done_reg[s_araddr[2]], busy_w[s_araddr[2]]};
            OFF_ID: rd_mux = {29'h0, pos_reg};
            default: rd_err = 1'b1;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= RESP_OKAY;
        end else begin
            s_arready <= !s_rvalid && !s_arready && s_arvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_mux;
                s_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Ports
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        assign cfg_w[p].mode = dphp_mode_e'(cfg_reg[p][CFG_MODE_LSB +: 2]);
        assign cfg_w[p].inv_flag = cfg_reg[p][CFG_INVF_BIT];
        assign cfg_w[p].inv_ctrl = cfg_reg[p][CFG_INVC_BIT];
        assign cfg_w[p].timeout = cfg_reg[p][CFG_TMO_LSB +: 8];
        assign cfg_w[p].dir_mask = mask_reg[p];
        assign cfg_w[p].wdata = wdat_reg[p];
    end
    dphp_port u_even (
        .aclk(aclk), .aresetn(aresetn), .cfg(cfg_w[0]),
        .start(start_reg[0]), .pin_in(even_port_in),
        .pin_out(even_port_out), .busy(busy_w[0]),
        .done_pulse(done_w[0]), .tmo_pulse(tmo_w[0]), .rdata(rd_w[0])
    );
    dphp_port u_odd (
        .aclk(aclk), .aresetn(aresetn), .cfg(cfg_w[1]),
        .start(start_reg[1]), .pin_in(odd_port_in),
        .pin_out(odd_port_out), .busy(busy_w[1]),
        .done_pulse(done_w[1]), .tmo_pulse(tmo_w[1]), .rdata(rd_w[1])
    );

    a_odd_port: assert property (@(posedge aclk) disable iff (!aresetn)
        odd_port_num == even_port_num + 4'h1) else $error("port pair");
    a_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_bvalid) else $error("no write response");
    a_done_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        done_w[0] |=> done_reg[0]) else $error("done lost");
    a_hit_base: assert property (@(posedge aclk) disable iff (!aresetn)
        $stable(pos_reg) && host_addr == win_base |=> board_hit)
        else $error("window miss");
    c_write: cover property (@(posedge aclk) s_bvalid && s_bready);
    c_read: cover property (@(posedge aclk) s_rvalid && s_rready);
endmodule // dphp_top

// ---- dphp_periph_model.sv ----
// Peripheral model that answers one handshake port
`timescale 1ns/1ns
module dphp_periph_model
    import dphp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input dphp_pkg::dphp_pin_out_s pin_out,
    input wire logic inv_flag,
    input wire logic inv_ctrl,
    input wire logic ack_en,
    input wire logic [1:0] ack_dly,
    input wire logic oe_en,
    input wire logic [15:0] pdata,
    output dphp_pkg::dphp_pin_in_s pin_in
);
    logic flag;
    logic [1:0] cnt;
    logic [15:0] junk;
    logic ctl;
    assign ctl = pin_out.port_control_out ^ inv_ctrl;
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag <= 1'b0;
            cnt <= 2'h0;
            junk <= 16'h5A5A;
        end else begin
            junk <= ~junk;
            cnt <= (ctl && !flag) ? cnt + 2'h1 : 2'h0;
            // Prompt or slow answer, chosen per transfer
            if (ctl && ack_en && cnt == ack_dly) flag <= 1'b1;
            if (!ctl) flag <= 1'b0;
        end
    end
    // Lines carry junk outside the flag, never a stale word
    assign pin_in.data_in = (pin_out.data_oe & pin_out.data_out) |
        (~pin_out.data_oe & (flag ? pdata : junk));
    assign pin_in.port_output_enable_in = oe_en;
    assign pin_in.peripheral_flag_in = flag ^ inv_flag;
endmodule // dphp_periph_model

// ---- dphp_top_tb_top.sv ----
// Self-checking bench for the dual parallel handshake port
`timescale 1ns/1ns
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin \
    err_count++; $display("mismatch %0t %s", $time, m); end end
module dphp_top_tb_top;
    import dphp_pkg::*;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } dphp_exp_s;
    int err_count = 0, checked = 0;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic board_select_bit0 = 1'b0, board_select_bit1 = 1'b0;
    logic board_select_bit2 = 1'b0, unused_switch = 1'b0;
    logic [15:0] host_addr = 16'h0;
    logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
    logic s_bready = 1'b1, s_rready = 1'b1;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, board_hit;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic [3:0] even_port_num, odd_port_num;
    dphp_pin_out_s po [2];
    dphp_pin_in_s pi [2];
    logic [1:0] inv_f = 2'h0, inv_c = 2'h0, ack_en = 2'h3, oe_en = 2'h3;
    logic [1:0] ack_dly [2] = '{2'h0, 2'h0};
    logic [15:0] pdata [2] = '{16'h0, 16'h0};
    int ctl_cyc [2] = '{0, 0};
    dphp_exp_s notes [$];
    logic [1:0] bnotes [$];
    initial begin
        forever #2 aclk = ~aclk;
    end
    dphp_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .board_select_bit0(board_select_bit0),
        .board_select_bit1(board_select_bit1),
        .board_select_bit2(board_select_bit2),
        .unused_switch(unused_switch), .host_addr(host_addr),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .board_hit(board_hit),
        .even_port_num(even_port_num), .odd_port_num(odd_port_num),
        .even_port_in(pi[0]), .even_port_out(po[0]),
        .odd_port_in(pi[1]), .odd_port_out(po[1]));
    for (genvar g = 0; g < 2; g++) begin : g_per
        dphp_periph_model u_per (.aclk(aclk), .aresetn(aresetn),
            .pin_out(po[g]), .inv_flag(inv_f[g]), .inv_ctrl(inv_c[g]),
            .ack_en(ack_en[g]), .ack_dly(ack_dly[g]), .oe_en(oe_en[g]),
            .pdata(pdata[g]), .pin_in(pi[g]));
    end
    // -----------------------------------------------
    // Result watcher: oldest note against each answer
    // -----------------------------------------------
    always @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (po[i].port_control_out ^ inv_c[i]) ctl_cyc[i]++;
        end
        if (s_rvalid === 1'b1 && s_rready) begin
            dphp_exp_s nt;
            nt = notes.pop_front();
            `CHK(s_rdata & nt.m, nt.d & nt.m, "read data")
            `CHK(s_rresp, nt.r, "read resp")
        end
        if (s_bvalid === 1'b1 && s_bready) begin
            `CHK(s_bresp, bnotes.pop_front(), "write resp")
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bit aw, w;
        int n;
        aw = 0;
        w = 0;
        bnotes.push_back(er);
        s_awaddr <= {24'h0, a};
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (s_awvalid && s_awready === 1'b1) begin
                aw = 1;
                s_awvalid <= 1'b0;
            end
            if (s_wvalid && s_wready === 1'b1) begin
                w = 1;
                s_wvalid <= 1'b0;
            end
            if (aw && w && s_bvalid === 1'b1) break;
        end
        if (n == 200) begin err_count++; summarize(); end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [31:0] em, input logic [1:0] er,
                      output logic [31:0] got);
        int n;
        notes.push_back({ed, em, er});
        s_araddr <= {24'h0, a};
        s_arvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (s_arvalid && s_arready === 1'b1) s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1) break;
        end
        got = s_rdata;
        if (n == 200) begin err_count++; summarize(); end
    endtask
    task automatic wait_stat(input int p, input int b);
        logic [31:0] v;
        int n;
        for (n = 0; n < 400; n++) begin
            rd(OFF_STAT0 + 8'(4 * p), 32'h0, 32'h0, RESP_OKAY, v);
            if (v[b] === 1'b1) break;
        end
        if (n == 400) begin err_count++; summarize(); end
    endtask
    // -----------------------------------------------
    // Main sequence
    // -----------------------------------------------
    initial begin
        logic [31:0] d, v, mk;
        int p, c0;
        int offs [4] = '{-1, 0, 7, 8};
        void'($urandom(32'h64A9761D));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(OFF_CFG0, CFG_RESET, 32'hFFFFFFFF, RESP_OKAY, v);
        rd(OFF_MASK1, 32'h0, 32'h0000FFFF, RESP_OKAY, v);
        rd(8'h24, 32'h0, 32'hFFFFFFFF, RESP_SLVERR, v);
        wr(8'h24, 32'h0, RESP_SLVERR);
        // Only byte one may land; the other bytes keep their reset value
        s_wstrb <= 4'h2;
        wr(OFF_CFG1, 32'hAAAA3C55, RESP_OKAY);
        s_wstrb <= 4'hF;
        rd(OFF_CFG1, 32'h00003C00, 32'hFFFFFFFF, RESP_OKAY, v);
        $display("test registers done");
        for (int pos = 0; pos < 8; pos++) begin
            {board_select_bit2, board_select_bit1, board_select_bit0} <=
                3'(pos);
            repeat (4) @(posedge aclk);
            for (int k = 0; k < 4; k++) begin
                unused_switch <= 1'($urandom);
                host_addr <= HOST_BASE + WIN_STEP * 16'(pos) + 16'(offs[k]);
                repeat (3) @(posedge aclk);
                `CHK(board_hit, 1'(k == 1 || k == 2), "hit")
            end
            `CHK(even_port_num, {3'(pos), 1'b0}, "even num")
            `CHK(odd_port_num, {3'(pos), 1'b1}, "odd num")
            rd(OFF_ID, 32'(pos), 32'h7, RESP_OKAY, v);
        end
        $display("test decode done");
        for (int m = 0; m < 4; m++) begin
            p = m % 2;
            d = $urandom;
            mk = (m == 0) ? {16'h0, 16'($urandom)} :
                ((m == 1) ? 32'h0 : 32'hFFFF);
            wr(OFF_CFG0 + 8'(4 * p),
               {16'h0, 8'h04, 4'h0, {2{m[1]}}, 2'(m)}, RESP_OKAY);
            wr(OFF_MASK0 + 8'(4 * p), mk, RESP_OKAY);
            inv_f[p] <= m[1];
            inv_c[p] <= m[1];
            ack_dly[p] <= 2'($urandom);
            pdata[p] <= 16'($urandom);
            repeat (8) @(posedge aclk);
            c0 = ctl_cyc[p];
            wr(OFF_DATA0 + 8'(4 * p), d, RESP_OKAY);
            wait_stat(p, STAT_DONE_BIT);
            rd(OFF_STAT0 + 8'(4 * p), 32'h2, 32'h7, RESP_OKAY, v);
            `CHK(po[p].port_direction_out, 1'(m != 1 && |mk), "dir")
            `CHK(po[p].port_control_out, m[1], "ctl idle")
            `CHK(ctl_cyc[p] - c0 > 0, m != 0, "ctl seen")
            if (m == 3) `CHK(ctl_cyc[p] - c0, 4, "strobe")
            if (m == 1) rd(OFF_DATA0 + 8'(4 * p), 32'(pdata[p]),
                           32'hFFFF, RESP_OKAY, v);
            else `CHK(po[p].data_out, d[15:0], "out")
            `CHK(po[p].data_oe, mk[15:0], "oe")
            wr(OFF_STAT0 + 8'(4 * p), 32'h7, RESP_OKAY);
            $display("test mode %0d done", m);
        end
        ack_en[0] <= 1'b0;
        wr(OFF_CFG0, {16'h0, 8'h01, 4'h0, 2'h3, 2'h2}, RESP_OKAY);
        c0 = ctl_cyc[0];
        wr(OFF_DATA0, 32'h0000A55A, RESP_OKAY);
        wait_stat(0, STAT_TMO_BIT);
        `CHK(po[0].port_control_out, 1'b1, "ctl after timeout")
        `CHK(ctl_cyc[0] - c0 <= 2 * TICK_CYC + 8, 1'b1, "tmo span")
        `CHK(ctl_cyc[0] - c0 >= TICK_CYC, 1'b1, "tmo early")
        wr(OFF_STAT0, 32'h7, RESP_OKAY);
        ack_en[0] <= 1'b1;
        $display("test timeout done");
        oe_en[1] <= 1'b0;
        repeat (8) @(posedge aclk);
        `CHK(po[1].data_oe, 16'h0, "oe off")
        oe_en[1] <= 1'b1;
        repeat (8) @(posedge aclk);
        `CHK(po[1].data_oe, 16'hFFFF, "oe on")
        $display("test output enable done");
        summarize();
    end
endmodule // dphp_top_tb_top
